//--- logic/lbmdi_pkg.sv
package lbmdi_pkg;

   // Pages of the device register space
   localparam logic [1:0] PG_ENABLE = 2'h0;
   localparam logic [1:0] PG_DUTY   = 2'h1;
   localparam logic [1:0] PG_MODE   = 2'h2;
   localparam logic [1:0] PG_FUNC   = 2'h3;

   // Function page offsets
   localparam logic [7:0] FN_CONFIG     = 8'h00;
   localparam logic [7:0] FN_CURRENT    = 8'h01;
   localparam logic [7:0] FN_PROF_FIRST = 8'h02;
   localparam logic [7:0] FN_PROF_LAST  = 8'h0D;
   localparam logic [7:0] FN_COMMIT     = 8'h0E;
   localparam logic [7:0] FN_OPEN_FIRST = 8'h18;
   localparam logic [7:0] FN_OPEN_LAST  = 8'h2F;
   localparam logic [7:0] FN_SHRT_FIRST = 8'h30;
   localparam logic [7:0] FN_SHRT_LAST  = 8'h47;
   localparam logic [7:0] FN_MASK       = 8'hF0;
   localparam logic [7:0] FN_FLAGS      = 8'hF1;

   // Field positions and values
   localparam int         CFG_BREATH   = 1;
   localparam int         CFG_DETECT   = 2;
   localparam int         IRQ_OPEN     = 0;
   localparam int         IRQ_SHORT    = 1;
   localparam int         IRQ_PROF     = 2;
   localparam int         IRQ_AUTO     = 5;
   localparam logic [1:0] LOOP_END_ON  = 2'h1;
   localparam logic [1:0] MODE_PLAIN   = 2'h0;
   localparam logic [7:0] COMMIT_KEY   = 8'h00;
   localparam logic [7:0] DETECT_LEVEL = 8'h01;
   localparam logic [7:0] REG_RESET    = 8'h00;
   localparam int         PROFILES     = 3;

   // Timing at 20 MHz
   localparam int CLK_MHZ          = 20;
   localparam int BREATH_UNIT_US   = 210000;
   localparam int STEP_CYC_DEF     = BREATH_UNIT_US * CLK_MHZ / 256;
   localparam int DETECT_US        = 3264;
   localparam int DETECT_CYC_DEF   = DETECT_US * CLK_MHZ;
   localparam int AUTO_CLR_US      = 8000;
   localparam int AUTO_CLR_CYC_DEF = AUTO_CLR_US * CLK_MHZ;

   // Controller register map and commands
   localparam logic [3:0] HC_CMD    = 4'h0;
   localparam logic [3:0] HC_PAGE   = 4'h1;
   localparam logic [3:0] HC_ADDR   = 4'h2;
   localparam logic [3:0] HC_DATA   = 4'h3;
   localparam logic [3:0] HC_STATUS = 4'h4;
   localparam logic [3:0] HC_RESULT = 4'h5;
   localparam logic [3:0] HC_GAMMA  = 4'h6;
   localparam logic [2:0] CMD_WRITE   = 3'h1;
   localparam logic [2:0] CMD_READ    = 3'h2;
   localparam logic [2:0] CMD_COMMIT  = 3'h3;
   localparam logic [2:0] CMD_BREATH  = 3'h4;
   localparam logic [2:0] CMD_DETECT  = 3'h5;
   localparam logic [2:0] CMD_SERVICE = 3'h6;

   // Gamma curve, 32 steps
   localparam logic [7:0] GAMMA32 [32] = '{
      8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0A, 8'h0D, 8'h12,
      8'h16, 8'h1C, 8'h21, 8'h27, 8'h2E, 8'h35, 8'h3D, 8'h45,
      8'h4E, 8'h56, 8'h60, 8'h6A, 8'h74, 8'h7E, 8'h8A, 8'h95,
      8'hA1, 8'hAD, 8'hBA, 8'hC7, 8'hD4, 8'hE2, 8'hF0, 8'hFF};

   typedef enum logic [1:0] {PH_RISE, PH_HOLD, PH_FALL, PH_OFF} lbmdi_phase_t;
   typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_GAP, HS_WAIT} lbmdi_hstate_t;

   typedef struct packed {
      logic       last;
      logic       rd;
      logic [1:0] page;
      logic [7:0] addr;
      logic [7:0] data;
   } lbmdi_op_t;

endpackage

//--- logic/lbmdi_link_if.sv
`timescale 1ns/1ps
interface lbmdi_link_if;
   logic [1:0] page;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       int_n;

   modport dev  (input page, addr, wdata, wr, rd, output rdata, int_n);
   modport host (output page, addr, wdata, wr, rd, input rdata, int_n);
endinterface

//--- logic/lbmdi_device.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module lbmdi_device import lbmdi_pkg::*; #(
   parameter int DOTS         = 192,
   parameter int STEP_CYC     = STEP_CYC_DEF,
   parameter int DETECT_CYC   = DETECT_CYC_DEF,
   parameter int AUTO_CLR_CYC = AUTO_CLR_CYC_DEF
) (
   // Clock and control
   input  wire logic              REF_CLK,
   input  wire logic              RESET,
   input  wire logic              CE,
   // Host link
   lbmdi_link_if.dev              LINK,
   // Detector inputs
   input  wire logic [DOTS-1:0]   DOT_OPEN,
   input  wire logic [DOTS-1:0]   DOT_SHORT,
   // Drive levels
   output logic      [8*DOTS-1:0] DOT_LEVEL,
   output logic      [7:0]        GLOBAL_LEVEL
);

   logic [7:0]  cfg_reg, mask_reg, flags_reg, rdata_reg, pend_reg [12], act_reg [12];
   logic [7:0]  duty_reg [DOTS];
   logic [1:0]  mode_reg [DOTS];
   logic [DOTS-1:0] en_reg, open_reg, short_reg;
   logic        int_n_reg, ben_prev_reg, osd_prev_reg, start_reg, det_busy_reg;
   logic [31:0] step_cnt_reg, det_cnt_reg, irq_tmr_reg;
   logic [7:0]  rd_val;
   logic [7:0]  prof_lvl [PROFILES];
   logic [PROFILES-1:0] prof_done;

   function automatic logic [17:0] phase_len(lbmdi_phase_t ph, logic [7:0] a, logic [7:0] b);
      case (ph)
         PH_RISE: phase_len = 18'h00100 << a[7:5];
         PH_HOLD: phase_len = (a[4:1] == 4'h0) ? 18'h0 : 18'h00100 << (a[4:1] - 4'h1);
         PH_FALL: phase_len = 18'h00100 << b[7:5];
         default: phase_len = (b[4:1] == 4'h0) ? 18'h0 : 18'h00100 << (b[4:1] - 4'h1);
      endcase
   endfunction

   function automatic lbmdi_phase_t begin_phase(logic [1:0] code);
      case (code)
         2'h0:    begin_phase = PH_RISE;
         2'h1:    begin_phase = PH_HOLD;
         2'h2:    begin_phase = PH_FALL;
         default: begin_phase = PH_OFF;
      endcase
   endfunction

   // Decode
   wire         is_func   = LINK.page == PG_FUNC;
   wire         wr_func   = LINK.wr && is_func;
   wire         in_dots   = int'(LINK.addr) < DOTS;
   wire         in_prof   = LINK.addr >= FN_PROF_FIRST && LINK.addr <= FN_PROF_LAST;
   wire         in_open   = LINK.addr >= FN_OPEN_FIRST && LINK.addr <= FN_OPEN_LAST;
   wire         in_shrt   = LINK.addr >= FN_SHRT_FIRST && LINK.addr <= FN_SHRT_LAST;
   wire [3:0]   prof_idx  = 4'(LINK.addr - FN_PROF_FIRST);
   wire [4:0]   open_idx  = 5'(LINK.addr - FN_OPEN_FIRST);
   wire [4:0]   shrt_idx  = 5'(LINK.addr - FN_SHRT_FIRST);
   wire [255:0] en_pad    = 256'(en_reg);
   wire [255:0] open_pad  = 256'(open_reg);
   wire [255:0] shrt_pad  = 256'(short_reg);
   wire         commit_wr = wr_func && LINK.addr == FN_COMMIT && LINK.wdata == COMMIT_KEY;
   wire         breath_on = cfg_reg[CFG_BREATH];
   wire         step_tick = step_cnt_reg == 32'(STEP_CYC - 1);
   wire         osd_rise  = cfg_reg[CFG_DETECT] && !osd_prev_reg;
   wire         det_done  = det_busy_reg && det_cnt_reg == 32'(DETECT_CYC - 1);
   wire         flag_read = LINK.rd && is_func && LINK.addr == FN_FLAGS;
   wire         auto_rel  = mask_reg[IRQ_AUTO] && !int_n_reg
                            && irq_tmr_reg == 32'(AUTO_CLR_CYC - 1);
   wire         release_i = flag_read || auto_rel;
   wire [4:0]   events    = {prof_done, det_done && |short_reg, det_done && |open_reg};
   wire [4:0]   hits      = events & mask_reg[4:0];

   always_comb begin
      rd_val = 8'h00;
      case (LINK.page)
         PG_ENABLE: if (LINK.addr < 8'h20) rd_val = en_pad[LINK.addr[4:0]*8 +: 8];
         PG_DUTY:   if (in_dots) rd_val = duty_reg[LINK.addr];
         PG_MODE:   if (in_dots) rd_val = {6'h00, mode_reg[LINK.addr]};
         default: begin
            if (LINK.addr == FN_CONFIG) rd_val = cfg_reg;
            else if (LINK.addr == FN_CURRENT) rd_val = GLOBAL_LEVEL;
            else if (in_prof) rd_val = pend_reg[prof_idx];
            else if (in_open) rd_val = open_pad[open_idx*8 +: 8];
            else if (in_shrt) rd_val = shrt_pad[shrt_idx*8 +: 8];
            else if (LINK.addr == FN_MASK) rd_val = mask_reg;
            else if (LINK.addr == FN_FLAGS) rd_val = flags_reg;
         end
      endcase
   end

   // Register file
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         cfg_reg <= REG_RESET;
         GLOBAL_LEVEL <= REG_RESET;
         mask_reg <= REG_RESET;
         rdata_reg <= REG_RESET;
         en_reg <= '0;
         for (int i = 0; i < 12; i++) begin
            pend_reg[i] <= REG_RESET;
            act_reg[i] <= REG_RESET;
         end
         for (int i = 0; i < DOTS; i++) begin
            duty_reg[i] <= REG_RESET;
            mode_reg[i] <= MODE_PLAIN;
         end
      end else if (CE) begin
         if (LINK.rd) rdata_reg <= rd_val;
         if (wr_func && LINK.addr == FN_CONFIG) cfg_reg <= LINK.wdata;
         if (wr_func && LINK.addr == FN_CURRENT) GLOBAL_LEVEL <= LINK.wdata;
         if (wr_func && LINK.addr == FN_MASK) mask_reg <= LINK.wdata;
         if (wr_func && in_prof) pend_reg[prof_idx] <= LINK.wdata;
         if (commit_wr) act_reg <= pend_reg;
         for (int i = 0; i < DOTS; i++) begin
            if (LINK.wr && LINK.page == PG_ENABLE && int'(LINK.addr) == i / 8)
               en_reg[i] <= LINK.wdata[i % 8];
         end
         if (LINK.wr && LINK.page == PG_DUTY && in_dots) duty_reg[LINK.addr] <= LINK.wdata;
         if (LINK.wr && LINK.page == PG_MODE && in_dots) mode_reg[LINK.addr] <= LINK.wdata[1:0];
      end
   end

   // Step timebase and start of profiles
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         step_cnt_reg <= '0;
         ben_prev_reg <= 1'b0;
         start_reg <= 1'b0;
      end else if (CE) begin
         step_cnt_reg <= step_tick ? 32'h0 : step_cnt_reg + 32'h1;
         ben_prev_reg <= breath_on;
         start_reg <= commit_wr || (breath_on && !ben_prev_reg);
      end
   end

   // Breath profile engines
   for (genvar p = 0; p < PROFILES; p++) begin : g_prof
      lbmdi_phase_t ph_reg;
      logic         run_reg, tail_reg, done_reg;
      logic [17:0]  pos_reg;
      logic [11:0]  cnt_reg;
      wire  [7:0]   r1    = act_reg[4*p];
      wire  [7:0]   r2    = act_reg[4*p+1];
      wire  [7:0]   r3    = act_reg[4*p+2];
      wire  [11:0]  total = {r3[3:0], act_reg[4*p+3]};
      wire  [17:0]  len   = phase_len(ph_reg, r1, r2);
      wire          adv   = run_reg && step_tick && (pos_reg + 18'h1 >= len);
      wire          last  = total != 12'h0 && cnt_reg + 12'h1 == total;
      wire  [7:0]   up    = 8'(pos_reg >> r1[7:5]);
      wire  [7:0]   down  = 8'hFF - 8'(pos_reg >> r2[7:5]);

      assign prof_lvl[p] = ph_reg == PH_RISE ? up : ph_reg == PH_HOLD ? 8'hFF :
                           ph_reg == PH_FALL ? down : 8'h00;
      assign prof_done[p] = done_reg;

      always_ff @(posedge REF_CLK) begin
         if (RESET) begin
            ph_reg <= PH_OFF;
            run_reg <= 1'b0;
            tail_reg <= 1'b0;
            done_reg <= 1'b0;
            pos_reg <= '0;
            cnt_reg <= '0;
         end else if (CE) begin
            done_reg <= 1'b0;
            if (!breath_on) begin
               run_reg <= 1'b0;
            end else if (start_reg) begin
               ph_reg <= begin_phase(r3[5:4]);
               run_reg <= 1'b1;
               tail_reg <= 1'b0;
               pos_reg <= '0;
               cnt_reg <= '0;
            end else if (adv) begin
               pos_reg <= '0;
               case (ph_reg)
                  PH_RISE: begin
                     ph_reg <= PH_HOLD;
                     if (tail_reg) begin
                        run_reg <= 1'b0;
                        done_reg <= 1'b1;
                     end
                  end
                  PH_HOLD: ph_reg <= PH_FALL;
                  PH_FALL: begin
                     ph_reg <= PH_OFF;
                     cnt_reg <= cnt_reg + 12'h1;
                     if (last && r3[7:6] == LOOP_END_ON) begin
                        tail_reg <= 1'b1;
                     end else if (last) begin
                        run_reg <= 1'b0;
                        done_reg <= 1'b1;
                     end
                  end
                  PH_OFF: ph_reg <= PH_RISE;
                  default: ph_reg <= PH_OFF;
               endcase
            end else if (run_reg && step_tick) begin
               pos_reg <= pos_reg + 18'h1;
            end
         end
      end
   end

   // Dot levels
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         DOT_LEVEL <= '0;
      end else if (CE) begin
         for (int i = 0; i < DOTS; i++) begin
            if (mode_reg[i] == MODE_PLAIN || !breath_on)
               DOT_LEVEL[i*8 +: 8] <= duty_reg[i];
            else
               DOT_LEVEL[i*8 +: 8] <= prof_lvl[mode_reg[i] - 2'h1];
         end
      end
   end

   // Open/short detection
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         osd_prev_reg <= 1'b0;
         det_busy_reg <= 1'b0;
         det_cnt_reg <= '0;
         open_reg <= '0;
         short_reg <= '0;
      end else if (CE) begin
         osd_prev_reg <= cfg_reg[CFG_DETECT];
         if (osd_rise) begin
            det_busy_reg <= 1'b1;
            det_cnt_reg <= '0;
            for (int i = 0; i < DOTS; i++) begin
               if (en_reg[i]) begin
                  open_reg[i] <= DOT_OPEN[i];
                  short_reg[i] <= DOT_SHORT[i];
               end
            end
         end else if (det_done) begin
            det_busy_reg <= 1'b0;
         end else if (det_busy_reg) begin
            det_cnt_reg <= det_cnt_reg + 32'h1;
         end
      end
   end

   // Interrupt output and flags
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         flags_reg <= REG_RESET;
         int_n_reg <= 1'b1;
         irq_tmr_reg <= '0;
      end else if (CE) begin
         flags_reg <= (release_i ? 8'h00 : flags_reg) | {3'h0, hits};
         if (|hits)
            int_n_reg <= 1'b0;
         else if (release_i)
            int_n_reg <= 1'b1;
         if (int_n_reg || release_i)
            irq_tmr_reg <= '0;
         else
            irq_tmr_reg <= irq_tmr_reg + 32'h1;
      end
   end

   assign LINK.rdata = rdata_reg;
   assign LINK.int_n = int_n_reg;

endmodule

//--- logic/lbmdi_host.sv
`timescale 1ns/1ps
module lbmdi_host import lbmdi_pkg::*; #(
   parameter int DETECT_CYC = DETECT_CYC_DEF
) (
   // Clock and control
   input  wire logic       REF_CLK,
   input  wire logic       RESET,
   input  wire logic       CE,
   // Device link
   lbmdi_link_if.host      LINK,
   // Software port
   input  wire logic [3:0] SW_ADDR,
   input  wire logic [7:0] SW_WDATA,
   input  wire logic       SW_WR,
   input  wire logic       SW_RD,
   output logic      [7:0] SW_RDATA
);

   lbmdi_hstate_t state_reg;
   logic [2:0]    cmd_reg, step_reg;
   logic [1:0]    page_reg, lk_page_reg;
   logic [7:0]    addr_reg, data_reg, cfg_reg, result_reg, lk_addr_reg, lk_wdata_reg;
   logic          lk_wr_reg, lk_rd_reg, rd_pend_reg, ready_reg, g64_reg;
   logic [5:0]    gidx_reg;
   logic [31:0]   wait_reg;
   logic [7:0]    sw_val;

   function automatic lbmdi_op_t seq_op(logic [2:0] cmd, logic [2:0] step, logic [7:0] cfg,
                                        logic [1:0] pg, logic [7:0] ad, logic [7:0] dt);
      seq_op = '{1'b1, 1'b0, PG_FUNC, FN_COMMIT, COMMIT_KEY};
      case (cmd)
         CMD_WRITE:   seq_op = '{1'b1, 1'b0, pg, ad, dt};
         CMD_READ:    seq_op = '{1'b1, 1'b1, pg, ad, 8'h00};
         CMD_BREATH:  if (step != 3'h0)
                         seq_op = '{1'b1, 1'b0, PG_FUNC, FN_CONFIG,
                                    cfg | 8'(1 << CFG_BREATH)};
                      else
                         seq_op.last = 1'b0;
         CMD_DETECT: begin
            case (step)
               3'h0:    seq_op = '{1'b0, 1'b0, PG_FUNC, FN_CURRENT, DETECT_LEVEL};
               3'h1:    seq_op = '{1'b0, 1'b0, PG_FUNC, FN_CONFIG,
                                   cfg & ~8'(1 << CFG_DETECT)};
               default: seq_op = '{1'b1, 1'b0, PG_FUNC, FN_CONFIG,
                                   cfg | 8'(1 << CFG_DETECT)};
            endcase
         end
         CMD_SERVICE: seq_op = '{1'b1, 1'b1, PG_FUNC, FN_FLAGS, 8'h00};
         default:     seq_op = '{1'b1, 1'b0, PG_FUNC, FN_COMMIT, COMMIT_KEY};
      endcase
   endfunction

   function automatic logic [7:0] gamma(logic [5:0] idx, logic wide);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = wide ? idx[5:1] : idx[4:0];
      hi = (lo == 5'h1F) ? lo : lo + 5'h1;
      if (wide && idx[0])
         gamma = 8'(({1'b0, GAMMA32[lo]} + {1'b0, GAMMA32[hi]}) >> 1);
      else
         gamma = GAMMA32[lo];
   endfunction

   wire lbmdi_op_t op      = seq_op(cmd_reg, step_reg, cfg_reg, page_reg, addr_reg, data_reg);
   wire            idle    = state_reg == HS_IDLE;
   wire            launch  = SW_WR && SW_ADDR == HC_CMD && idle && SW_WDATA[2:0] != 3'h0;
   wire            cfg_wr  = op.page == PG_FUNC && op.addr == FN_CONFIG && !op.rd;
   wire            wait_ok = wait_reg == 32'(DETECT_CYC - 1);

   always_comb begin
      sw_val = 8'h00;
      case (SW_ADDR)
         HC_CMD:    sw_val = {5'h00, cmd_reg};
         HC_PAGE:   sw_val = {6'h00, page_reg};
         HC_ADDR:   sw_val = addr_reg;
         HC_DATA:   sw_val = data_reg;
         HC_STATUS: sw_val = {5'h00, !LINK.int_n, ready_reg, !idle};
         HC_RESULT: sw_val = result_reg;
         HC_GAMMA:  sw_val = gamma(gidx_reg, g64_reg);
         default:   sw_val = 8'h00;
      endcase
   end

   // Software registers
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         page_reg <= PG_FUNC;
         addr_reg <= 8'h00;
         data_reg <= 8'h00;
         gidx_reg <= 6'h00;
         g64_reg <= 1'b0;
         SW_RDATA <= 8'h00;
      end else if (CE) begin
         if (SW_RD) SW_RDATA <= sw_val;
         if (SW_WR && SW_ADDR == HC_PAGE) page_reg <= SW_WDATA[1:0];
         if (SW_WR && SW_ADDR == HC_ADDR) addr_reg <= SW_WDATA;
         if (SW_WR && SW_ADDR == HC_DATA) data_reg <= SW_WDATA;
         if (SW_WR && SW_ADDR == HC_GAMMA) begin
            gidx_reg <= SW_WDATA[5:0];
            g64_reg <= SW_WDATA[7];
         end
      end
   end

   // Link sequencer
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         state_reg <= HS_IDLE;
         cmd_reg <= 3'h0;
         step_reg <= 3'h0;
         cfg_reg <= REG_RESET;
         result_reg <= 8'h00;
         lk_page_reg <= PG_FUNC;
         lk_addr_reg <= 8'h00;
         lk_wdata_reg <= 8'h00;
         lk_wr_reg <= 1'b0;
         lk_rd_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         ready_reg <= 1'b0;
         wait_reg <= '0;
      end else if (CE) begin
         lk_wr_reg <= 1'b0;
         lk_rd_reg <= 1'b0;
         rd_pend_reg <= lk_rd_reg;
         if (rd_pend_reg) result_reg <= LINK.rdata;
         case (state_reg)
            HS_IDLE: if (launch) begin
               cmd_reg <= SW_WDATA[2:0];
               step_reg <= 3'h0;
               if (SW_WDATA[2:0] == CMD_DETECT) ready_reg <= 1'b0;
               state_reg <= HS_ISSUE;
            end
            HS_ISSUE: begin
               lk_page_reg <= op.page;
               lk_addr_reg <= op.addr;
               lk_wdata_reg <= op.data;
               lk_wr_reg <= !op.rd;
               lk_rd_reg <= op.rd;
               if (cfg_wr) cfg_reg <= op.data;
               state_reg <= HS_GAP;
            end
            HS_GAP: begin
               step_reg <= step_reg + 3'h1;
               wait_reg <= '0;
               if (!op.last) state_reg <= HS_ISSUE;
               else if (cmd_reg == CMD_DETECT) state_reg <= HS_WAIT;
               else state_reg <= HS_IDLE;
            end
            HS_WAIT: begin
               wait_reg <= wait_reg + 32'h1;
               if (wait_ok) begin
                  ready_reg <= 1'b1;
                  state_reg <= HS_IDLE;
               end
            end
            default: state_reg <= HS_IDLE;
         endcase
      end
   end

   assign LINK.page  = lk_page_reg;
   assign LINK.addr  = lk_addr_reg;
   assign LINK.wdata = lk_wdata_reg;
   assign LINK.wr    = lk_wr_reg;
   assign LINK.rd    = lk_rd_reg;

endmodule

//--- sim/lbmdi_link_sva.sv
`timescale 1ns/1ps
module lbmdi_link_sva import lbmdi_pkg::*; #(parameter int AUTO_CLR_CYC = AUTO_CLR_CYC_DEF) (
   // Clock and reset
   input wire logic       REF_CLK,
   input wire logic       RESET,
   // Link
   input wire logic [1:0] page,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       int_n
);
   logic [7:0] mask_reg, cfg_reg, cur_reg;
   int         low_reg;
   wire        fn_wr   = wr && page == PG_FUNC;
   wire        flag_rd = rd && page == PG_FUNC && addr == FN_FLAGS;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   always_ff @(posedge REF_CLK) begin
      mask_reg <= RESET ? 8'h00 : (fn_wr && addr == FN_MASK) ? wdata : mask_reg;
      cfg_reg  <= RESET ? 8'h00 : (fn_wr && addr == FN_CONFIG) ? wdata : cfg_reg;
      cur_reg  <= RESET ? 8'h00 : (fn_wr && addr == FN_CURRENT) ? wdata : cur_reg;
      low_reg  <= (RESET || int_n) ? 0 : low_reg + 1;
   end
   a_no_overlap: assert property (!(wr && rd))
      else $error("wr and rd together");
   a_strobe_pulse: assert property ((wr || rd) |=> !(wr || rd))
      else $error("link strobe too long");
   a_rdata_stands: assert property (!rd |=> $stable(rdata))
      else $error("rdata moved without rd");
   a_commit_key: assert property (fn_wr && addr == FN_COMMIT |-> wdata == COMMIT_KEY)
      else $error("commit with nonzero data");
   a_detect_level: assert property (fn_wr && addr == FN_CONFIG && wdata[CFG_DETECT]
      && !cfg_reg[CFG_DETECT] |-> cur_reg == DETECT_LEVEL) else $error("detect at wrong level");
   a_mask_gate: assert property ($fell(int_n) |-> mask_reg[4:0] != 5'h00)
      else $error("interrupt with all events masked");
   a_flag_release: assert property (flag_rd |=> int_n)
      else $error("interrupt held after flag read");
   a_hold_low: assert property (!int_n && !mask_reg[IRQ_AUTO] && !flag_rd |=> !int_n)
      else $error("interrupt released early");
   a_auto_bound: assert property (mask_reg[IRQ_AUTO] && !int_n |-> low_reg < AUTO_CLR_CYC + 1)
      else $error("auto clear late");
endmodule

//--- sim/lbmdi_bench.sv
`timescale 1ns/1ps
module lbmdi_bench import lbmdi_pkg::*;;
   logic       ref_clk = 1'b0, reset = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00, sw_rdata, v, global_level;
   logic       ce = 1'b1;
   logic [191:0] dot_open = 192'h0, dot_short = 192'h0;
   logic [1535:0] dot_level;
   int         n_mismatch = 0, check_count = 0, cyc = 0, i;
   lbmdi_link_if link ();
   lbmdi_host #(.DETECT_CYC(20)) u_lbmdi_host (.REF_CLK(ref_clk), .RESET(reset), .CE(ce),
      .LINK(link.host), .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd),
      .SW_RDATA(sw_rdata));
   lbmdi_device #(.STEP_CYC(4), .DETECT_CYC(20), .AUTO_CLR_CYC(200)) u_lbmdi_device (
      .REF_CLK(ref_clk), .RESET(reset), .CE(ce), .LINK(link.dev), .DOT_OPEN(dot_open),
      .DOT_SHORT(dot_short), .DOT_LEVEL(dot_level), .GLOBAL_LEVEL(global_level));
   lbmdi_link_sva #(.AUTO_CLR_CYC(200)) u_lbmdi_link_sva (.REF_CLK(ref_clk), .RESET(reset),
      .page(link.page), .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
      .rdata(link.rdata), .int_n(link.int_n));
   always #25 ref_clk = ~ref_clk;
   task test_done;
      $display("Mismatches %0d of %0d checks", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         test_done;
      end
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task sw_w(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk) {sw_addr, sw_wdata, sw_wr} <= {a, d, 1'b1};
      @(posedge ref_clk) sw_wr <= 1'b0;
   endtask
   task sw_r(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk) {sw_addr, sw_rd} <= {a, 1'b1};
      @(posedge ref_clk) sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask
   task op(input logic [2:0] cmd, input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
      int k;
      sw_w(HC_PAGE, {6'h00, pg});
      sw_w(HC_ADDR, a);
      sw_w(HC_DATA, d);
      sw_w(HC_CMD, {5'h00, cmd});
      v = 8'h01;
      for (k = 0; k < 60 && v[0] !== 1'b0; k++) sw_r(HC_STATUS, v);
   endtask
   task rdc(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] exp);
      op(CMD_READ, pg, a, 8'h00);
      sw_r(HC_RESULT, v);
      chk(v, exp);
   endtask
   task irq(input logic [7:0] exp);
      sw_r(HC_STATUS, v);
      chk({7'h00, v[2]}, exp);
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      rdc(PG_FUNC, FN_MASK, REG_RESET);
      sw_w(HC_GAMMA, 8'h1F);
      sw_r(HC_GAMMA, v);
      chk(v, GAMMA32[31]);
      sw_w(HC_GAMMA, 8'hA0);
      sw_r(HC_GAMMA, v);
      chk(v, GAMMA32[16]);
      op(CMD_WRITE, PG_ENABLE, 8'h00, 8'h0F);
      op(CMD_WRITE, PG_DUTY, 8'h00, 8'h04);
      for (i = 1; i < 4; i++) op(CMD_WRITE, PG_MODE, i[7:0], i[7:0]);
      op(CMD_WRITE, PG_FUNC, FN_MASK, 8'h04);
      op(CMD_WRITE, PG_FUNC, FN_PROF_FIRST + 8'h03, 8'h01);
      chk(dot_level[7:0], 8'h04);
      op(CMD_BREATH, PG_FUNC, 8'h00, 8'h00);
      repeat (600) @(posedge ref_clk);
      for (i = 1; i < 4; i++) chk({7'h00, dot_level[8*i +: 8] != 8'h00}, 8'h01);
      @(posedge ref_clk) ce <= 1'b0;
      @(posedge ref_clk) #1 v = dot_level[15:8];
      repeat (20) @(posedge ref_clk);
      chk(dot_level[15:8], v);
      ce <= 1'b1;
      chk(dot_level[7:0], 8'h04);
      repeat (2000) @(posedge ref_clk);
      chk(dot_level[15:8], 8'h00);
      irq(8'h01);
      op(CMD_SERVICE, PG_FUNC, FN_FLAGS, 8'h00);
      sw_r(HC_RESULT, v);
      chk(v, 8'h04);
      irq(8'h00);
      op(CMD_WRITE, PG_ENABLE, 8'h00, 8'h01);
      op(CMD_WRITE, PG_FUNC, FN_MASK, 8'h21);
      op(CMD_WRITE, PG_FUNC, FN_CURRENT, DETECT_LEVEL);
      chk(global_level, DETECT_LEVEL);
      @(posedge ref_clk) dot_open <= 192'h3;
      op(CMD_DETECT, PG_FUNC, 8'h00, 8'h00);
      repeat (25) @(posedge ref_clk);
      irq(8'h01);
      rdc(PG_FUNC, FN_OPEN_FIRST, 8'h01);
      repeat (250) @(posedge ref_clk);
      irq(8'h00);
      rdc(PG_FUNC, FN_FLAGS, 8'h00);
      op(CMD_WRITE, PG_ENABLE, 8'h00, 8'h03);
      @(posedge ref_clk) {dot_open, dot_short} <= {192'h2, 192'h1};
      op(CMD_DETECT, PG_FUNC, 8'h00, 8'h00);
      repeat (25) @(posedge ref_clk);
      rdc(PG_FUNC, FN_OPEN_FIRST, 8'h02);
      rdc(PG_FUNC, FN_SHRT_FIRST, 8'h01);
      test_done;
   end
endmodule
